/* File: hdl/frcc_pkg.sv */
package frcc_pkg;

  // ==========================================================================
  // Flash geometry
  // ==========================================================================
  localparam int ADDR_W   = 19;
  localparam int LINE_AW  = ADDR_W - 4;
  localparam int PAGE_W   = 10;
  localparam int PB_N     = 128;
  localparam int PB_IW    = 7;
  localparam int LOCK_N   = 16;
  localparam int LOCK_SH  = 6;
  localparam int NVB_N    = 3;
  localparam int DESC_LEN = 4 + 1 + 1 + LOCK_N;
  localparam logic [31:0] FLASH_BYTES = 32'h0008_0000;
  localparam logic [31:0] PAGE_BYTES  = 32'h0000_0200;
  localparam logic [31:0] LOCK_BYTES  = 32'h0000_8000;
  // Interface identifier word; the value is arbitrary.
  localparam logic [31:0] IFACE_ID    = 32'h0000_0001;
  localparam logic [7:0]  CMD_KEY     = 8'h5A;

  // ==========================================================================
  // Register map and fields
  // ==========================================================================
  localparam logic [7:0]  OFF_MODE    = 8'h00;
  localparam logic [7:0]  OFF_CMD     = 8'h04;
  localparam logic [7:0]  OFF_STAT    = 8'h08;
  localparam logic [7:0]  OFF_RES     = 8'h0C;
  localparam logic [31:0] MODE_RST    = 32'h0000_0000;
  localparam int MODE_IRQ_BIT = 0;
  localparam int MODE_WS_LSB  = 8;
  localparam int WS_W         = 4;
  localparam int KEY_LSB      = 24;
  localparam int ARG_LSB      = 8;
  localparam int STAT_DONE    = 0;
  localparam int STAT_CERR    = 1;
  localparam int STAT_LERR    = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [7:0] {
    CMD_GET_DESCRIPTOR = 8'h00, CMD_WP = 8'h01, CMD_PROGRAM_PROTECT = 8'h02, CMD_ERASE_PROGRAM = 8'h03,
    CMD_ERASE_PROGRAM_PROTECT = 8'h04, CMD_FULL_ERASE = 8'h05, CMD_SET_PROTECT = 8'h08,
    CMD_CLEAR_PROTECT = 8'h09, CMD_GET_PROTECT = 8'h0A, CMD_SNV = 8'h0B, CMD_CNV = 8'h0C, CMD_GNV = 8'h0D
  } frcc_cmd_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1, ST_EXEC = 3'h2, ST_RUN = 3'h4
  } frcc_st_type;

  typedef struct packed {
    logic              code;
    logic [1:0]        size;
    logic [ADDR_W-1:0] addr;
  } frcc_rdreq_type;

  typedef struct packed {
    logic              valid;
    logic [7:0]        op;
    logic [PAGE_W-1:0] page;
  } frcc_arrop_type;

endpackage : frcc_pkg

/* File: hdl/frcc_top.sv */
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Interrupt pulses only when the command-done flag rises.
// - Two 128-bit code buffers prefetch the next line, gaps allowed.
// - A 128-bit data buffer plus a 128-bit prefetch slot; a served data line prefetches the next line.
// - Write-only page buffer, one page, aliased across the 512 KByte space.
// - One protection bit per lock region guards its pages.
// - Commands set and clear general nonvolatile bits.
// - Get-descriptor returns size, page size and lock organisation.
// - Byte, halfword and word reads are served.
// - Only flash-size address bits are decoded, so the image repeats.
// - Read wait states follow the programmed field; zero is fastest.
// - Settings 1 to 3: first access slow, later sequential ones fast.
// - Settings 4 to 10: prefetch hides part of each new line fetch.
// - Reads wait while a command runs on the single plane.
// - Command codes decode as 0x0 to 0x5 and 0x8 to 0xD.
// - A command write clears done flag and result value.
// - Command end sets done flag and, if enabled, the interrupt.
// - Wrong key or code: plane untouched, command error, cleared by status read.
// - Write or erase in a locked region: lock error, cleared by status read.
// - Result reads step through the descriptor, then return zero.
module frcc_top
  import frcc_pkg::*;
(
  // Clock and reset
  input  wire logic           I_CORE_CLK,
  input  wire logic           I_RST_N,
  // AXI4-Lite register slave
  input  wire logic           I_AWVALID,
  output logic                O_AWREADY,
  input  wire logic [7:0]     I_AWADDR,
  input  wire logic           I_WVALID,
  output logic                O_WREADY,
  input  wire logic [31:0]    I_WDATA,
  input  wire logic [3:0]     I_WSTRB,
  output logic                O_BVALID,
  input  wire logic           I_BREADY,
  output logic [1:0]          O_BRESP,
  input  wire logic           I_ARVALID,
  output logic                O_ARREADY,
  input  wire logic [7:0]     I_ARADDR,
  output logic                O_RVALID,
  input  wire logic           I_RREADY,
  output logic [31:0]         O_RDATA,
  output logic [1:0]          O_RRESP,
  // Flash read port
  input  wire logic           I_RD_VALID,
  input  wire frcc_rdreq_type I_RD_REQ,
  output logic                O_RD_READY,
  output logic [31:0]         O_RD_DATA,
  // Page buffer write port
  input  wire logic           I_PB_WE,
  input  wire logic [PB_IW-1:0] I_PB_IDX,
  input  wire logic [31:0]    I_PB_DATA,
  // Flash array
  output logic                O_ARR_REN,
  output logic [LINE_AW-1:0]  O_ARR_RADDR,
  input  wire logic [127:0]   I_ARR_RDATA,
  output frcc_arrop_type      O_ARR_OP,
  input  wire logic           I_ARR_DONE,
  input  wire logic [PB_IW-1:0] I_ARR_WIDX,
  output logic [31:0]         O_ARR_WDATA,
  // Interrupt
  output logic                O_IRQ
);

  // ==========================================================================
  // Functions
  // ==========================================================================
  function automatic logic [31:0] desc_word(input logic [4:0] i);
    if (i == 5'h00) desc_word = IFACE_ID;
    else if (i == 5'h01) desc_word = FLASH_BYTES;
    else if (i == 5'h02) desc_word = PAGE_BYTES;
    else if (i == 5'h03) desc_word = 32'h0000_0001;
    else if (i == 5'h04) desc_word = FLASH_BYTES;
    else if (i == 5'h05) desc_word = 32'h0000_0010;
    else if (i < 5'(DESC_LEN)) desc_word = LOCK_BYTES;
    else desc_word = 32'h0000_0000;
  endfunction : desc_word

  function automatic logic [31:0] lane(input logic [127:0] ln, input logic [3:0] a,
                                       input logic [1:0] sz);
    logic [31:0] w;
    w = ln[32*a[3:2] +: 32];
    if (sz == 2'h0) lane = {24'h0, w[8*a[1:0] +: 8]};
    else if (sz == 2'h1) lane = {16'h0, w[16*a[1] +: 16]};
    else lane = w;
  endfunction : lane

  function automatic logic code_ok(input logic [7:0] c);
    code_ok = (c <= 8'h05) || (c >= 8'h08 && c <= 8'h0D);
  endfunction : code_ok

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic rs1, rst_n;
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rs1   <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1   <= 1'b1;
      rst_n <= rs1;
    end
  end

  // ==========================================================================
  // Register state
  // ==========================================================================
  logic [31:0]       mode;
  logic [31:0]       cmd_q;
  logic [31:0]       res;
  logic              done, done_q, cerr, lerr, desc_on;
  logic [4:0]        desc_idx;
  logic [LOCK_N-1:0] lock;
  logic [NVB_N-1:0]  nvb;
  frcc_st_type       st;
  logic [WS_W-1:0]   ws;
  logic              irq_en;
  assign ws     = mode[MODE_WS_LSB +: WS_W];
  assign irq_en = mode[MODE_IRQ_BIT];

  // ==========================================================================
  // AXI4-Lite slave
  // ==========================================================================
  logic       aw_h, w_h;
  logic [7:0] aw_a;
  logic [31:0] w_d;
  logic [3:0] w_s;
  logic       wr_go, cmd_wr, ar_go, stat_rd, res_rd;
  assign O_AWREADY = !aw_h && !O_BVALID;
  assign O_WREADY  = !w_h && !O_BVALID;
  assign O_ARREADY = !O_RVALID;
  assign wr_go     = aw_h && w_h && !O_BVALID;
  assign cmd_wr    = wr_go && aw_a == OFF_CMD;
  assign ar_go     = I_ARVALID && O_ARREADY;
  assign stat_rd   = ar_go && I_ARADDR == OFF_STAT;
  assign res_rd    = ar_go && I_ARADDR == OFF_RES;

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_h     <= 1'b0;
      w_h      <= 1'b0;
      aw_a     <= 8'h00;
      w_d      <= 32'h0000_0000;
      w_s      <= 4'h0;
      O_BVALID <= 1'b0;
      O_BRESP  <= RESP_OKAY;
      mode     <= MODE_RST;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_h <= 1'b1;
        aw_a <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_h <= 1'b1;
        w_d <= I_WDATA;
        w_s <= I_WSTRB;
      end
      if (wr_go) begin
        aw_h     <= 1'b0;
        w_h      <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP  <= (aw_a[7:4] == 4'h0 && aw_a[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
        if (aw_a == OFF_MODE) begin
          for (int b = 0; b < 4; b++) begin
            if (w_s[b]) mode[8*b +: 8] <= w_d[8*b +: 8];
          end
        end
      end else if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_RVALID <= 1'b0;
      O_RDATA  <= 32'h0000_0000;
      O_RRESP  <= RESP_OKAY;
    end else if (ar_go) begin
      O_RVALID <= 1'b1;
      O_RRESP  <= RESP_OKAY;
      unique case (I_ARADDR)
        OFF_MODE: O_RDATA <= mode;
        OFF_CMD:  O_RDATA <= 32'h0000_0000;
        OFF_STAT: O_RDATA <= {29'h0, lerr, cerr, done};
        OFF_RES:  O_RDATA <= desc_on ? desc_word(desc_idx) : res;
        default: begin
          O_RDATA <= 32'h0000_0000;
          O_RRESP <= RESP_SLVERR;
        end
      endcase
    end else if (O_RVALID && I_RREADY) begin
      O_RVALID <= 1'b0;
    end
  end

  // ==========================================================================
  // Command sequencer
  // ==========================================================================
  logic [7:0]        c_code;
  logic [PAGE_W-1:0] c_page;
  logic [3:0]        c_reg;
  logic              c_bad, c_prog, c_lkd, f_busy;
  assign c_code = cmd_q[7:0];
  assign c_page = cmd_q[ARG_LSB +: PAGE_W];
  assign c_reg  = c_page[PAGE_W-1 -: 4];
  assign c_bad  = cmd_q[KEY_LSB +: 8] != CMD_KEY || !code_ok(c_code);
  assign c_prog = c_code >= CMD_WP && c_code <= CMD_FULL_ERASE;
  assign c_lkd  = (c_code == CMD_FULL_ERASE) ? |lock : lock[c_reg];

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st       <= ST_IDLE;
      cmd_q    <= 32'h0000_0000;
      done     <= 1'b1;
      cerr     <= 1'b0;
      lerr     <= 1'b0;
      res      <= 32'h0000_0000;
      desc_on  <= 1'b0;
      desc_idx <= 5'h00;
      lock     <= '0;
      nvb      <= '0;
    end else begin
      if (stat_rd) begin
        cerr <= 1'b0;
        lerr <= 1'b0;
      end
      if (res_rd && desc_on && desc_idx < 5'(DESC_LEN)) desc_idx <= desc_idx + 5'h01;
      unique case (st)
        ST_IDLE: begin
          // Writes during a running command are dropped to keep it atomic.
          if (cmd_wr) begin
            cmd_q   <= w_d;
            done    <= 1'b0;
            res     <= 32'h0000_0000;
            desc_on <= 1'b0;
            st      <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (c_bad) begin
            cerr <= 1'b1;
            done <= 1'b1;
            st   <= ST_IDLE;
          end else if (c_prog && c_lkd) begin
            lerr <= 1'b1;
            done <= 1'b1;
            st   <= ST_IDLE;
          end else if (c_prog) begin
            if (!f_busy) st <= ST_RUN;
          end else begin
            done <= 1'b1;
            st   <= ST_IDLE;
            unique case (c_code)
              CMD_GET_DESCRIPTOR: begin
                desc_on  <= 1'b1;
                desc_idx <= 5'h00;
              end
              CMD_SET_PROTECT:   lock[c_reg] <= 1'b1;
              CMD_CLEAR_PROTECT: lock[c_reg] <= 1'b0;
              CMD_GET_PROTECT:   res <= 32'(lock);
              CMD_SNV: if (c_page < PAGE_W'(NVB_N)) nvb[c_page[1:0]] <= 1'b1;
              CMD_CNV: if (c_page < PAGE_W'(NVB_N)) nvb[c_page[1:0]] <= 1'b0;
              CMD_GNV: res <= 32'(nvb);
              default: res <= 32'h0000_0000;
            endcase
          end
        end
        ST_RUN: begin
          if (I_ARR_DONE) begin
            if (c_code == CMD_PROGRAM_PROTECT || c_code == CMD_ERASE_PROGRAM_PROTECT) lock[c_reg] <= 1'b1;
            done <= 1'b1;
            st   <= ST_IDLE;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  assign O_ARR_OP = '{valid: st == ST_RUN, op: c_code, page: c_page};

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b1;
      O_IRQ  <= 1'b0;
    end else begin
      done_q <= done;
      O_IRQ  <= done && !done_q && irq_en;
    end
  end

  // ==========================================================================
  // Page buffer
  // ==========================================================================
  logic [31:0] pbuf [PB_N];
  always_ff @(posedge I_CORE_CLK) begin
    if (I_PB_WE) pbuf[I_PB_IDX] <= I_PB_DATA;
    O_ARR_WDATA <= pbuf[I_ARR_WIDX];
  end

  // ==========================================================================
  // Read buffers and line fetch
  // ==========================================================================
  // Slots 0 and 1 hold code lines, slot 2 the current data line and slot 3
  // the prefetched data line, so a data prefetch never evicts a line in use.
  logic [127:0]       bd [4];
  logic [LINE_AW-1:0] bt [4];
  logic [3:0]         bv;
  logic [LINE_AW-1:0] la, la_nx;
  logic [3:0]         hv;
  logic               hit, serve, miss, c_lru, cmd_busy, pf_go;
  logic [1:0]         hs, pf_dst;
  logic [WS_W-1:0]    f_cnt;
  logic [1:0]         f_dst;

  assign la       = I_RD_REQ.addr[ADDR_W-1:4];
  assign la_nx    = la + LINE_AW'(1);
  assign cmd_busy = st != ST_IDLE;

  always_comb begin
    for (int k = 0; k < 4; k++) hv[k] = bv[k] && bt[k] == la;
    if (I_RD_REQ.code) begin
      hit = hv[0] || hv[1];
      hs  = hv[1] ? 2'h1 : 2'h0;
    end else begin
      hit = hv[2] || hv[3];
      hs  = hv[3] ? 2'h3 : 2'h2;
    end
  end

  assign serve = I_RD_VALID && hit && !cmd_busy && !O_RD_READY;
  assign miss  = I_RD_VALID && !hit && !cmd_busy && !(f_busy && O_ARR_RADDR == la);
  // A served code line prefetches its successor into the other code slot; a
  // data line that is served prefetches its successor into slot 3.
  always_comb begin
    pf_dst = I_RD_REQ.code ? {1'b0, !hs[0]} : 2'h3;
    pf_go  = serve && !f_busy && !(I_RD_REQ.code ? (hv[0] ^ hv[1]) && (bv[pf_dst] &&
             bt[pf_dst] == la_nx) : bv[3] && bt[3] == la_nx);
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_RD_READY <= 1'b0;
      O_RD_DATA  <= 32'h0000_0000;
      c_lru      <= 1'b0;
    end else begin
      O_RD_READY <= serve;
      if (serve) begin
        O_RD_DATA <= lane(bd[hs], I_RD_REQ.addr[3:0], I_RD_REQ.size);
        if (I_RD_REQ.code) c_lru <= !hs[0];
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      f_busy      <= 1'b0;
      f_cnt       <= '0;
      f_dst       <= 2'h0;
      O_ARR_RADDR <= '0;
      bv          <= 4'h0;
      for (int k = 0; k < 4; k++) begin
        bt[k] <= '0;
        bd[k] <= '0;
      end
    end else begin
      // A demand miss aborts a prefetch of another line; the wait count is the setting.
      if (miss) begin
        f_busy      <= 1'b1;
        f_cnt       <= ws;
        O_ARR_RADDR <= la;
        f_dst       <= I_RD_REQ.code ? {1'b0, c_lru} : 2'h2;
      end else if (pf_go) begin
        f_busy      <= 1'b1;
        f_cnt       <= ws;
        O_ARR_RADDR <= la_nx;
        f_dst       <= pf_dst;
      end else if (f_busy && f_cnt != '0) begin
        f_cnt <= f_cnt - WS_W'(1);
      end else if (f_busy) begin
        f_busy       <= 1'b0;
        bd[f_dst]    <= I_ARR_RDATA;
        bt[f_dst]    <= O_ARR_RADDR;
        bv[f_dst]    <= 1'b1;
      end
      if (serve && hs == 2'h3) begin
        bd[2] <= bd[3];
        bt[2] <= bt[3];
        bv[2] <= 1'b1;
        bv[3] <= 1'b0;
      end
      if (st == ST_RUN && I_ARR_DONE) bv <= 4'h0;
    end
  end

  assign O_ARR_REN = f_busy;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!rst_n);

  chk_irq_rise: assert property (O_IRQ |-> $past(done) && !$past(done_q) && $past(irq_en))
    else $error("Interrupt without a done rise.");
  chk_irq_fire: assert property ($rose(done) && irq_en |=> O_IRQ)
    else $error("Done rise missed its interrupt.");
  chk_cmd_clear: assert property (cmd_wr && st == ST_IDLE |=> !done && res == 32'h0 && st == ST_EXEC)
    else $error("Command write did not clear done and result.");
  chk_bad_cmd: assert property (st == ST_EXEC && c_bad |=> cerr && done && !O_ARR_OP.valid)
    else $error("Bad command not flagged or reached the array.");
  chk_err_read: assert property (stat_rd && st != ST_EXEC |=> !cerr && !lerr)
    else $error("Status read left an error flag set.");
  chk_lock_err: assert property (st == ST_EXEC && !c_bad && c_prog && c_lkd |=> lerr && st == ST_IDLE)
    else $error("Locked page was not refused.");
  chk_rd_wait: assert property (cmd_busy |-> ##1 !O_RD_READY)
    else $error("Read served while a command ran.");
  chk_one_op: assert property (O_ARR_OP.valid |-> !f_busy && !O_ARR_REN)
    else $error("Array read overlaps a command.");
  chk_ws_count: assert property (miss && ws == 4'h2 |=> f_busy [*3] ##1 !f_busy)
    else $error("Fetch length differs from the wait setting.");
  chk_desc_end: assert property (res_rd && desc_on && desc_idx >= 5'(DESC_LEN) |=> O_RDATA == 32'h0)
    else $error("Descriptor read past end is not zero.");

  cov_get_descriptor_cmd: cover property (st == ST_EXEC && !c_bad && c_code == CMD_GET_DESCRIPTOR);
  cov_lock: cover property (st == ST_EXEC && !c_bad && c_prog && c_lkd);
  cov_prefetch: cover property (pf_go ##[1:20] serve && hs == pf_dst);
  cov_irq: cover property (O_IRQ);

endmodule : frcc_top
`default_nettype wire

/* File: test/frcc_arr_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================================
// Flash array model
// ============================================================================
module frcc_arr_model
  import frcc_pkg::*;
#(
  parameter int OP_CYC = 20
)(
  // Clock
  input  wire logic               i_clk,
  // Array side of the controller
  input  wire logic               i_ren,
  input  wire logic [LINE_AW-1:0] i_raddr,
  input  wire frcc_arrop_type     i_op,
  output logic [127:0]            o_rdata,
  output logic                    o_done,
  output logic [PB_IW-1:0]        o_widx
);
  int cnt = 0;

  // Outside a fetch the line is inverted, so stale data never passes for valid.
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      o_rdata[32*k +: 32] = {13'h0, i_raddr, 2'(k), 2'h0} ^ 32'hC3C3_0000;
    end
    if (!i_ren) begin
      o_rdata = ~o_rdata;
    end
  end

  // A program or erase takes OP_CYC cycles, then done pulses once.
  always_ff @(posedge i_clk) begin
    cnt <= i_op.valid ? cnt + 1 : 0;
  end
  assign o_done = i_op.valid && cnt == OP_CYC;
  assign o_widx = cnt[PB_IW-1:0];
endmodule : frcc_arr_model
`default_nettype wire

/* File: test/test_flash_read_and_command_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module test_flash_read_and_command_ctrl
  import frcc_pkg::*;
;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, rd_valid, pb_we;
  logic awready, wready, bvalid, arready, rvalid, rd_ready, arr_ren, arr_done, irq;
  logic [7:0]         awaddr, araddr;
  logic [31:0]        wdata, rdata, rd_data, pb_data, arr_wdata, rv;
  logic [3:0]         wstrb;
  logic [1:0]         bresp, rresp, rr;
  frcc_rdreq_type     rd_req;
  logic [PB_IW-1:0]   pb_idx, arr_widx;
  logic [LINE_AW-1:0] arr_raddr;
  logic [127:0]       arr_rdata;
  frcc_arrop_type     arr_op;
  int n_fail = 0, n_tests = 0, cyc = 0, n_irq = 0, lat, h;

  frcc_top frcc_top_i (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr),
    .I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata), .I_WSTRB(wstrb), .O_BVALID(bvalid),
    .I_BREADY(bready), .O_BRESP(bresp), .I_ARVALID(arvalid), .O_ARREADY(arready), .I_ARADDR(araddr),
    .O_RVALID(rvalid), .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp), .I_RD_VALID(rd_valid),
    .I_RD_REQ(rd_req), .O_RD_READY(rd_ready), .O_RD_DATA(rd_data), .I_PB_WE(pb_we), .I_PB_IDX(pb_idx),
    .I_PB_DATA(pb_data), .O_ARR_REN(arr_ren), .O_ARR_RADDR(arr_raddr), .I_ARR_RDATA(arr_rdata),
    .O_ARR_OP(arr_op), .I_ARR_DONE(arr_done), .I_ARR_WIDX(arr_widx), .O_ARR_WDATA(arr_wdata), .O_IRQ(irq));

  frcc_arr_model frcc_arr_model_i (
    .i_clk(clk), .i_ren(arr_ren), .i_raddr(arr_raddr), .i_op(arr_op),
    .o_rdata(arr_rdata), .o_done(arr_done), .o_widx(arr_widx));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // The run should need a few hundred cycles; the ceiling leaves wide margin.
  always @(posedge clk) begin
    cyc++;
    if (irq === 1'b1) n_irq++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // Polls status until done; the last read also clears the error flags.
  task automatic cmd(input logic [7:0] code, input logic [15:0] arg, input logic [7:0] key);
    int i;
    axi_wr(OFF_CMD, {key, arg, code});
    i = 0;
    do begin
      axi_rd(OFF_STAT, rv, rr);
      i++;
    end while (rv[STAT_DONE] !== 1'b1 && i < 200);
  endtask : cmd

  task automatic frd(input logic code, input logic [1:0] sz, input logic [18:0] a, output logic [31:0] d);
    rd_req   <= '{code: code, size: sz, addr: a};
    rd_valid <= 1'b1;
    lat = 0;
    do begin
      @(posedge clk);
      lat++;
    end while (!rd_ready && lat < 200);
    d = rd_data;
    rd_valid <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : frd

  function automatic logic [31:0] exp_w(input logic [18:0] a);
    return {13'h0, a[18:2], 2'h0} ^ 32'hC3C3_0000;
  endfunction : exp_w

  function automatic logic [31:0] exp_d(input int i);
    case (i)
      0: return IFACE_ID;
      1, 4: return FLASH_BYTES;
      2: return PAGE_BYTES;
      3: return 32'h1;
      5: return 32'(LOCK_N);
      default: return i < DESC_LEN ? LOCK_BYTES : 32'h0;
    endcase
  endfunction : exp_d

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_cmds();
    logic [7:0] bad [4] = '{8'h06, 8'h07, 8'h0E, 8'hFF};
    axi_rd(OFF_MODE, rv, rr);
    chk(rv, MODE_RST);
    axi_rd(8'h10, rv, rr);
    chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    axi_wr(8'h10, 32'h0);
    chk({30'h0, bresp}, {30'h0, RESP_SLVERR});
    cmd(CMD_GET_DESCRIPTOR, 16'h0, 8'hA5);
    chk(rv, 32'h3);
    foreach (bad[i]) begin
      cmd(bad[i], 16'h0, CMD_KEY);
      chk(rv, 32'h3);
      axi_rd(OFF_STAT, rv, rr);
      chk(rv, 32'h1);
    end
    cmd(CMD_GET_DESCRIPTOR, 16'h0, CMD_KEY);
    for (int i = 0; i <= DESC_LEN; i++) begin
      axi_rd(OFF_RES, rv, rr);
      chk(rv, exp_d(i));
    end
  endtask : t_cmds

  task automatic t_lock();
    cmd(CMD_SET_PROTECT, 16'd64, CMD_KEY);
    cmd(CMD_GET_PROTECT, 16'd0, CMD_KEY);
    axi_rd(OFF_RES, rv, rr);
    chk(rv, 32'h2);
    cmd(CMD_WP, 16'd70, CMD_KEY);
    chk(rv, 32'h5);
    cmd(CMD_FULL_ERASE, 16'd0, CMD_KEY);
    chk(rv, 32'h5);
    axi_rd(OFF_STAT, rv, rr);
    chk(rv, 32'h1);
    cmd(CMD_SNV, 16'd1, CMD_KEY);
    cmd(CMD_GNV, 16'd0, CMD_KEY);
    axi_rd(OFF_RES, rv, rr);
    chk(rv, 32'h2);
    cmd(CMD_CNV, 16'd1, CMD_KEY);
    cmd(CMD_GNV, 16'd0, CMD_KEY);
    axi_rd(OFF_RES, rv, rr);
    chk(rv, 32'h0);
    cmd(CMD_CLEAR_PROTECT, 16'd64, CMD_KEY);
    cmd(CMD_GET_PROTECT, 16'd0, CMD_KEY);
    axi_rd(OFF_RES, rv, rr);
    chk(rv, 32'h0);
  endtask : t_lock

  // A command written while another runs is dropped, so the lock of page 0 must
  // not appear; the descriptor left open before the program must be cleared.
  task automatic t_prog();
    for (int i = 0; i < 4; i++) begin
      pb_idx  <= PB_IW'(i);
      pb_data <= 32'h5A5A_0000 + 32'(i);
      pb_we   <= 1'b1;
      @(posedge clk);
    end
    pb_we <= 1'b0;
    cmd(CMD_GET_DESCRIPTOR, 16'h0, CMD_KEY);
    axi_wr(OFF_MODE, 32'h1);
    chk(arr_wdata, 32'h5A5A_0000);
    h = n_irq;
    axi_wr(OFF_CMD, {CMD_KEY, 16'd70, 8'(CMD_WP)});
    axi_rd(OFF_STAT, rv, rr);
    chk(rv, 32'h0);
    axi_rd(OFF_RES, rv, rr);
    chk(rv, 32'h0);
    cmd(CMD_SET_PROTECT, 16'd0, CMD_KEY);
    chk(rv, 32'h1);
    cmd(CMD_ERASE_PROGRAM_PROTECT, 16'd70, CMD_KEY);
    chk(rv, 32'h1);
    repeat (3) @(posedge clk);
    chk(32'(n_irq - h), 32'h2);
    axi_wr(OFF_MODE, 32'h0);
    cmd(CMD_GET_PROTECT, 16'd0, CMD_KEY);
    axi_rd(OFF_RES, rv, rr);
    chk(rv, 32'h2);
    repeat (3) @(posedge clk);
    chk(32'(n_irq - h), 32'h2);
    cmd(CMD_CLEAR_PROTECT, 16'd70, CMD_KEY);
  endtask : t_prog

  task automatic t_read();
    int m;
    frd(1'b0, 2'h2, 19'h00100, rv);
    m = lat;
    frd(1'b0, 2'h2, 19'h00104, rv);
    h = lat;
    chk(rv, exp_w(19'h00104));
    chk(32'(m - h), 32'h2);
    frd(1'b0, 2'h0, 19'h00105, rv);
    chk(rv, {24'h0, 8'(exp_w(19'h00104) >> 8)});
    frd(1'b0, 2'h1, 19'h00106, rv);
    chk(rv, {16'h0, 16'(exp_w(19'h00104) >> 16)});
    axi_wr(OFF_MODE, 32'h0000_0200);
    frd(1'b0, 2'h2, 19'h02000, rv);
    chk(32'(lat - h), 32'h4);
    frd(1'b0, 2'h2, 19'h02004, rv);
    frd(1'b0, 2'h2, 19'h02010, rv);
    chk(32'(lat), 32'(h));
    frd(1'b1, 2'h2, 19'h03000, rv);
    frd(1'b1, 2'h2, 19'h03010, rv);
    chk(32'(lat), 32'(h));
    chk(rv, exp_w(19'h03010));
  endtask : t_read

  task automatic complete_run();
    if (n_fail == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, rd_valid, pb_we} = '0;
    {awaddr, araddr, wdata, pb_data, pb_idx} = '0;
    wstrb  = 4'hF;
    rd_req = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_cmds();
    t_lock();
    t_prog();
    t_read();
    complete_run();
  end
endmodule : test_flash_read_and_command_ctrl
`default_nettype wire
